// [logic/rxocs_consts.svh]
// Constants for the receive output and clock select block.
// Assumes inclusion by bare name from logic/.
`ifndef RXOCS_CONSTS_SVH
`define RXOCS_CONSTS_SVH

`define RXOCS_ADDR_W       4
`define RXOCS_OFF_BLOCK    4'h0
`define RXOCS_OFF_RXCTL    4'h1
`define RXOCS_OFF_STATUS   4'h2
`define RXOCS_OFF_IRQ_STAT 4'h3
`define RXOCS_OFF_IRQ_MASK 4'h4
`define RXOCS_OFF_SYNDIV   4'h5
// Block control fields
`define RXOCS_BC_SINGLE    0
`define RXOCS_BC_E3        1
`define RXOCS_BC_STS1      2
// Receive control fields
`define RXOCS_RC_MON       0
`define RXOCS_RC_INV       1
// Interrupt bits
`define RXOCS_IRQ_LCV      0
`define RXOCS_IRQ_CFG      1
`define RXOCS_BLOCK_RST    8'h00
`define RXOCS_RXCTL_RST    8'h00
`define RXOCS_MASK_RST     8'h00
// Default synthesizer half periods in ref_clk cycles, per line mode
`define RXOCS_HALF_E3      8'h01
`define RXOCS_HALF_DS3     8'h01
`define RXOCS_HALF_STS1    8'h01
// Bench rates
`define RXOCS_REF_CLK_NS   25
`define RXOCS_LINK_CLK_NS  200

`endif

// [logic/rxocs_pkg.sv]
// Types for the receive output and clock select block.
// Assumes the constants header is compiled alongside.
package rxocs_pkg;

	typedef enum logic [1:0]
	{
		RXOCS_DS3  = 2'b00,
		RXOCS_E3   = 2'b01,
		RXOCS_STS1 = 2'b10
	} rxocs_line_t;

	typedef struct packed
	{
		logic        host_mode;
		logic        single_rail;
		logic        monitor;
		logic        clk_invert;
		logic        single_freq;
		rxocs_line_t line;
	} rxocs_cfg_t;

endpackage

// [logic/rxocs_sync.sv]
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes inputs come from outside the ref_clk domain.
`timescale 1ns/1ps

module rxocs_sync
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] nxt_meta;

	if (W < 1)
	begin
		$error("rxocs_sync: width must be positive");
	end

	always_comb
	begin
		nxt_meta = d;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			q       <= '0;
		end
		else
		begin
			meta_ff <= nxt_meta;
			q       <= meta_ff;
		end
	end

endmodule

// [logic/rxocs_top.sv]
// Receive output select and clock source select of a line interface.
// Assumes pins arrive asynchronously; recovered clock sampled by ref_clk.
// Summary of operation
// (RULE1) Dual rail: negative pulses appear on neg_data_or_violation.
// (RULE2) Hardware mode: outside holds rail_select high single, low dual.
// (RULE3) Host mode: rail selection comes from block control register bit.
// (RULE4) Single rail: output pulses high on each violation, else low.
// (RULE5) Framer should sample the violation output on recovered_clock.
// (RULE6) Hardware mode, monitor pin high: receiver enters monitoring mode.
// (RULE7) Host mode: monitoring mode enabled by receive control register.
// (RULE8) Host mode: monitor pin becomes serial data output.
// (RULE9) Outside supplies line-rate reference when not single frequency.
// (RULE10) Single frequency: 12.288 MHz in, synthesizer makes line clock.
// (RULE11) Single frequency: drive low-jitter clock on synth_clock_out.
// (RULE12) Synthesized clock frequency follows the selected line mode; the code takes the half period from the SYNDIV register instead.
// (RULE13) Undriven single_freq_enable reads low; default off.
// (RULE14) select_a high is host mode, low hardware mode.
// (RULE15) Single rail enables line coder; dual rail disables it.
// (RULE16) Outputs update on recovered clock rise, or fall when inverted.
// (RULE17) Hardware: E3 pin chooses E3, else STS-1 pin STS-1 or DS3.
// (RULE18) Shared output function follows current rail selection only.
`timescale 1ns/1ps
`include "rxocs_consts.svh"

module rxocs_top
(
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// Mode pins
	input  wire logic                      select_a,
	input  wire logic                      rail_select,
	input  wire logic                      e3_select,
	input  wire logic                      sts1_select,
	input  wire logic                      rx_clock_invert,
	input  wire logic                      single_freq_enable,
	input  wire logic                      single_freq_enable_oe_n,
	// Shared monitor pin and serial data
	input  wire logic                      monitor_or_serial_in,
	output      logic                      monitor_or_serial_out,
	output      logic                      monitor_or_serial_oe_n,
	input  wire logic                      serial_data_out_int,
	// Receiver decisions
	input  wire logic                      recovered_clock_in,
	input  wire logic                      rx_pos_pulse,
	input  wire logic                      rx_neg_pulse,
	input  wire logic                      rx_code_violation,
	// Framer side
	output      logic                      recovered_clock,
	output      logic                      positive_data_out,
	output      logic                      neg_data_or_violation,
	// Status to analog and coder
	output      logic                      monitor_mode,
	output      logic                      coder_enable,
	output      logic                      synth_enable,
	output      logic [1:0]                line_mode,
	output      logic                      synth_clock_out,
	// Register port
	input  wire logic [`RXOCS_ADDR_W-1:0]  reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output      logic [7:0]                reg_rdata,
	// Interrupt
	output      logic                      irq
);

	localparam int NS = 9;

	logic [NS-1:0]         pin_raw;
	logic [NS-1:0]         pin_s;
	logic                  s_host;
	logic                  s_rail;
	logic                  s_e3;
	logic                  s_sts1;
	logic                  s_inv;
	logic                  s_sfm;
	logic                  s_mon;
	logic                  s_rclk;
	logic                  s_lcv;
	logic                  s_pos;
	logic                  s_neg;

	logic [7:0]            block_ff;
	logic [7:0]            nxt_block;
	logic [7:0]            rxctl_ff;
	logic [7:0]            nxt_rxctl;
	logic [7:0]            mask_ff;
	logic [7:0]            nxt_mask;
	logic [7:0]            istat_ff;
	logic [7:0]            nxt_istat;
	logic [7:0]            rdata_ff;
	logic [7:0]            nxt_rdata;
	logic [7:0]            half_ff;
	logic [7:0]            nxt_half;
	logic                  irq_ff;
	logic                  nxt_irq;

	rxocs_pkg::rxocs_cfg_t cfg;
	rxocs_pkg::rxocs_cfg_t cfg_ff;

	logic                  rclk_d_ff;
	logic                  pos_ff;
	logic                  nxt_pos;
	logic                  negv_ff;
	logic                  nxt_negv;
	logic                  rclk_out_ff;
	logic                  nxt_rclk_out;
	logic                  mon_out_ff;
	logic                  nxt_mon_out;
	logic                  mon_oe_ff;
	logic                  nxt_mon_oe;
	logic                  mon_mode_ff;
	logic                  coder_ff;
	logic                  synth_en_ff;
	logic [1:0]            line_ff;

	logic [7:0]            sdiv_ff;
	logic [7:0]            nxt_sdiv;
	logic                  sclk_ff;
	logic                  nxt_sclk;
	logic                  upd_edge;
	logic                  lcv_event;
	logic                  cfg_event;

	// Single-rail violation pulse samples and recovered data pass through sync
	assign pin_raw = {select_a, rail_select, e3_select, sts1_select,
		rx_clock_invert, single_freq_enable, monitor_or_serial_in,
		recovered_clock_in, single_freq_enable_oe_n};

	rxocs_sync #(.W(NS)) u_pins
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       (pin_raw),
		.q       (pin_s)
	);

	rxocs_sync #(.W(3)) u_data
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       ({rx_code_violation, rx_pos_pulse, rx_neg_pulse}),
		.q       ({s_lcv, s_pos, s_neg})
	);

	assign s_host = pin_s[8];
	assign s_rail = pin_s[7];
	assign s_e3   = pin_s[6];
	assign s_sts1 = pin_s[5];
	assign s_inv  = pin_s[4];
	assign s_sfm  = pin_s[3] & ~pin_s[0]; // Released pin reads low [RULE13]
	assign s_mon  = pin_s[2];
	assign s_rclk = pin_s[1];

	function automatic rxocs_pkg::rxocs_line_t line_of(input logic e3,
		input logic sts1);
		if (e3)
			line_of = rxocs_pkg::RXOCS_E3;
		else if (sts1)
			line_of = rxocs_pkg::RXOCS_STS1;
		else
			line_of = rxocs_pkg::RXOCS_DS3;
	endfunction

	// Configuration source: pins or registers
	always_comb
	begin
		cfg.host_mode   = s_host; // [RULE14]
		cfg.single_freq = s_sfm; // [RULE10]
		if (s_host)
		begin
			cfg.single_rail = block_ff[`RXOCS_BC_SINGLE]; // [RULE3]
			cfg.line        = line_of(block_ff[`RXOCS_BC_E3],
				block_ff[`RXOCS_BC_STS1]);
			cfg.monitor     = rxctl_ff[`RXOCS_RC_MON]; // [RULE7]
			cfg.clk_invert  = rxctl_ff[`RXOCS_RC_INV];
		end
		else
		begin
			cfg.single_rail = s_rail; // [RULE2]
			cfg.line        = line_of(s_e3, s_sts1); // [RULE17]
			cfg.monitor     = s_mon; // [RULE6]
			cfg.clk_invert  = s_inv;
		end
	end

	// Update on chosen recovered clock edge
	assign upd_edge  = cfg.clk_invert ? (rclk_d_ff & ~s_rclk)
		: (~rclk_d_ff & s_rclk); // [RULE16]
	assign lcv_event = upd_edge & cfg.single_rail & s_lcv;
	assign cfg_event = (cfg != cfg_ff);

	always_comb
	begin
		nxt_pos      = pos_ff;
		nxt_negv     = negv_ff;
		nxt_rclk_out = s_rclk;
		if (upd_edge)
		begin
			nxt_pos = s_pos;
			if (cfg.single_rail)
				nxt_negv = s_lcv; // [RULE4] [RULE18]
			else
				nxt_negv = s_neg; // [RULE1] [RULE18]
		end
	end

	// Shared pin: serial out in host mode, input otherwise
	always_comb
	begin
		nxt_mon_out = 1'b0;
		nxt_mon_oe  = 1'b1;
		if (cfg.host_mode)
		begin
			nxt_mon_out = serial_data_out_int; // [RULE8]
			nxt_mon_oe  = 1'b0;
		end
	end

	// Synthesizer divider, half period from the SYNDIV register
	always_comb
	begin
		nxt_sdiv = sdiv_ff;
		nxt_sclk = 1'b0;
		if (cfg.single_freq)
		begin
			nxt_sclk = sclk_ff; // [RULE11]
			if (sdiv_ff >= half_ff)
			begin
				nxt_sdiv = 8'h01;
				nxt_sclk = ~sclk_ff;
			end
			else
				nxt_sdiv = sdiv_ff + 8'h01;
		end
		else
			nxt_sdiv = 8'h01;
	end

	// Register file
	always_comb
	begin
		nxt_block = block_ff;
		nxt_rxctl = rxctl_ff;
		nxt_mask  = mask_ff;
		nxt_half  = half_ff;
		nxt_istat = istat_ff;
		nxt_rdata = 8'h00;
		if (reg_wr)
		begin
			case (reg_addr)
				`RXOCS_OFF_BLOCK:    nxt_block = reg_wdata;
				`RXOCS_OFF_RXCTL:    nxt_rxctl = reg_wdata;
				`RXOCS_OFF_IRQ_MASK: nxt_mask  = reg_wdata;
				`RXOCS_OFF_SYNDIV:   nxt_half  = reg_wdata;
				`RXOCS_OFF_IRQ_STAT: nxt_istat = istat_ff & ~reg_wdata;
				default:             nxt_half  = half_ff;
			endcase
		end
		// Set wins over clear
		if (lcv_event)
			nxt_istat[`RXOCS_IRQ_LCV] = 1'b1;
		if (cfg_event)
			nxt_istat[`RXOCS_IRQ_CFG] = 1'b1;
		if (reg_rd)
		begin
			case (reg_addr)
				`RXOCS_OFF_BLOCK:    nxt_rdata = block_ff;
				`RXOCS_OFF_RXCTL:    nxt_rdata = rxctl_ff;
				`RXOCS_OFF_STATUS:   nxt_rdata = {1'b0, cfg.host_mode,
					cfg.single_rail, cfg.monitor, cfg.clk_invert,
					cfg.single_freq, cfg.line};
				`RXOCS_OFF_IRQ_STAT: nxt_rdata = istat_ff;
				`RXOCS_OFF_IRQ_MASK: nxt_rdata = mask_ff;
				`RXOCS_OFF_SYNDIV:   nxt_rdata = half_ff;
				default:             nxt_rdata = 8'h00;
			endcase
		end
		nxt_irq = |(nxt_istat & nxt_mask);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			block_ff    <= `RXOCS_BLOCK_RST;
			rxctl_ff    <= `RXOCS_RXCTL_RST;
			mask_ff     <= `RXOCS_MASK_RST;
			half_ff     <= `RXOCS_HALF_DS3;
			istat_ff    <= 8'h00;
			rdata_ff    <= 8'h00;
			irq_ff      <= 1'b0;
			cfg_ff      <= '0;
			rclk_d_ff   <= 1'b0;
			pos_ff      <= 1'b0;
			negv_ff     <= 1'b0;
			rclk_out_ff <= 1'b0;
			mon_out_ff  <= 1'b0;
			mon_oe_ff   <= 1'b1;
			mon_mode_ff <= 1'b0;
			coder_ff    <= 1'b0;
			synth_en_ff <= 1'b0;
			line_ff     <= 2'h0;
			sdiv_ff     <= 8'h01;
			sclk_ff     <= 1'b0;
		end
		else
		begin
			block_ff    <= nxt_block;
			rxctl_ff    <= nxt_rxctl;
			mask_ff     <= nxt_mask;
			half_ff     <= nxt_half;
			istat_ff    <= nxt_istat;
			rdata_ff    <= nxt_rdata;
			irq_ff      <= nxt_irq;
			cfg_ff      <= cfg;
			rclk_d_ff   <= s_rclk;
			pos_ff      <= nxt_pos;
			negv_ff     <= nxt_negv;
			rclk_out_ff <= nxt_rclk_out;
			mon_out_ff  <= nxt_mon_out;
			mon_oe_ff   <= nxt_mon_oe;
			mon_mode_ff <= cfg.monitor; // [RULE6] [RULE7]
			coder_ff    <= cfg.single_rail; // [RULE15]
			synth_en_ff <= cfg.single_freq; // [RULE10]
			line_ff     <= cfg.line; // [RULE12]
			sdiv_ff     <= nxt_sdiv;
			sclk_ff     <= nxt_sclk;
		end
	end

	assign recovered_clock        = rclk_out_ff;
	assign positive_data_out      = pos_ff;
	assign neg_data_or_violation  = negv_ff;
	assign monitor_or_serial_out  = mon_out_ff;
	assign monitor_or_serial_oe_n = mon_oe_ff;
	assign monitor_mode           = mon_mode_ff;
	assign coder_enable           = coder_ff;
	assign synth_enable           = synth_en_ff;
	assign line_mode              = line_ff;
	assign synth_clock_out        = sclk_ff;
	assign reg_rdata              = rdata_ff;
	assign irq                    = irq_ff;

endmodule

// [test/rxocs_monitor.sv]
// Checker for the receive output and clock select block.
// Assumes binding to rxocs_top; pins settle within five cycles.
`timescale 1ns/1ps

module rxocs_monitor
(
	// Clock, reset and pins
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       select_a,
	input wire logic       rail_select,
	input wire logic       e3_select,
	input wire logic       sts1_select,
	input wire logic       single_freq_enable,
	input wire logic       single_freq_enable_oe_n,
	input wire logic       monitor_or_serial_in,
	// Outputs watched
	input wire logic       monitor_or_serial_oe_n,
	input wire logic       monitor_mode,
	input wire logic       coder_enable,
	input wire logic       synth_enable,
	input wire logic       synth_clock_out,
	input wire logic [1:0] line_mode
);
	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	coder_single_a:
	assert property ((!select_a && rail_select)[*5] |-> coder_enable)
		else $error("coder off in single rail");
	hw_monitor_a:
	assert property ((!select_a && monitor_or_serial_in)[*5] |-> monitor_mode)
		else $error("monitor mode not entered");
	host_drive_a:
	assert property (select_a[*5] |-> !monitor_or_serial_oe_n)
		else $error("serial pin not driven in host mode");
	hw_release_a:
	assert property ((!select_a)[*5] |-> monitor_or_serial_oe_n)
		else $error("serial pin driven in hardware mode");
	synth_off_a:
	assert property ((single_freq_enable_oe_n || !single_freq_enable)[*5]
		|-> !synth_enable && !synth_clock_out)
		else $error("synthesizer active while off");
	synth_on_a:
	assert property ((single_freq_enable && !single_freq_enable_oe_n)[*5]
		|-> synth_enable)
		else $error("synthesizer not enabled");
	e3_wins_a:
	assert property ((!select_a && e3_select)[*5] |-> line_mode == 2'h1)
		else $error("E3 pin ignored");
	sts1_pick_a:
	assert property ((!select_a && !e3_select && sts1_select)[*5]
		|-> line_mode == 2'h2)
		else $error("STS-1 pin ignored");
endmodule

// [test/rxocs_framer.sv]
// Framer model: samples the shared receive output at mid bit.
// Assumes outputs change on the rising recovered_clock edge.
`timescale 1ns/1ps

module rxocs_framer
(
	// Recovered side
	input  wire logic rst_n,
	input  wire logic recovered_clock,
	input  wire logic neg_data_or_violation,
	// Sampled value
	output      logic neg_seen
);
	// Sampled on the recovered clock, away from its update edge
	always_ff @(negedge recovered_clock or negedge rst_n)
	begin
		if (!rst_n)
			neg_seen <= 1'h0;
		else
			neg_seen <= neg_data_or_violation;
	end
endmodule

// [test/rxocs_top_tb.sv]
// Testbench for the receive output and clock select block.
// Assumes design, framer model and checker are compiled before it.
`timescale 1ns/1ps

module rxocs_top_tb;
	typedef struct packed
	{
		logic       rail, neg, lcv, e3, sts1, exp_neg;
		logic [1:0] exp_line;
	} rxocs_row_t;
	// Rail, negative, violation, E3, STS-1; expected output and mode
	rxocs_row_t rows [4] = '{8'h5D, 8'h2A, 8'hA4, 8'hD1};
	logic [3:0] rst_addr [5] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h9};
	logic [7:0] rst_val [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
	logic       ref_clk = 1'h0, rst_n = 1'h0, select_a = 1'h0;
	logic       rail_select = 1'h0, e3_select = 1'h0, sts1_select = 1'h0;
	logic       single_freq_enable = 1'h0, single_freq_enable_oe_n = 1'h1;
	logic       rx_clock_invert = 1'h0, mon_drv = 1'h0;
	logic       serial_data_out_int = 1'h0, recovered_clock_in = 1'h0;
	logic       rx_pos_pulse = 1'h0, rx_neg_pulse = 1'h0;
	logic       rx_code_violation = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       monitor_or_serial_in, monitor_or_serial_out;
	logic       monitor_or_serial_oe_n, recovered_clock, positive_data_out;
	logic       neg_data_or_violation, monitor_mode, coder_enable;
	logic       synth_enable, synth_clock_out, irq, neg_seen, prev;
	logic [1:0] line_mode;
	logic [7:0] reg_rdata;
	int         failures = 0, comparisons = 0, n;

	// Shared pin level from both drivers
	assign monitor_or_serial_in = monitor_or_serial_oe_n ? mon_drv
		: monitor_or_serial_out;
	always #12.5 ref_clk = ~ref_clk; // Reference to the block
	always #100 recovered_clock_in = ~recovered_clock_in;

	rxocs_top uut
	(
		.ref_clk, .rst_n, .select_a, .rail_select, .e3_select,
		.sts1_select, .rx_clock_invert, .single_freq_enable,
		.single_freq_enable_oe_n, .monitor_or_serial_in,
		.monitor_or_serial_out, .monitor_or_serial_oe_n,
		.serial_data_out_int, .recovered_clock_in, .rx_pos_pulse,
		.rx_neg_pulse, .rx_code_violation, .recovered_clock,
		.positive_data_out, .neg_data_or_violation, .monitor_mode,
		.coder_enable, .synth_enable, .line_mode, .synth_clock_out,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
	);

	rxocs_framer far_end
	(
		.rst_n, .recovered_clock, .neg_data_or_violation, .neg_seen
	);

	task automatic wait_cyc(input int k);
		repeat (k) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("mismatch %0t got %h exp %h", $time, got, exp);
			failures++;
		end
	endtask

	task automatic bit_chk(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'h0;
		#1;
		chk(reg_rdata, e);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		$display("mismatch %0t timeout", $time);
		failures++;
		give_verdict();
	end

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		foreach (rows[i])
		begin
			@(posedge ref_clk);
			rail_select       <= rows[i].rail;
			mon_drv           <= rows[i].rail;
			rx_neg_pulse      <= rows[i].neg;
			rx_pos_pulse      <= ~rows[i].neg;
			rx_code_violation <= rows[i].lcv;
			e3_select         <= rows[i].e3;
			sts1_select       <= rows[i].sts1;
			wait_cyc(40);
			bit_chk(neg_data_or_violation, rows[i].exp_neg);
			bit_chk(positive_data_out, ~rows[i].neg);
			bit_chk(neg_seen, rows[i].exp_neg);
			bit_chk(coder_enable, rows[i].rail);
			bit_chk(monitor_mode, rows[i].rail);
			chk({6'h00, line_mode}, {6'h00, rows[i].exp_line});
		end
		// Second reset, then register defaults and an unmapped read
		@(posedge ref_clk);
		rst_n <= 1'h0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		foreach (rst_addr[i])
			rd(rst_addr[i], rst_val[i]);
		// Host mode: register overrides the dual rail pin
		@(posedge ref_clk);
		select_a            <= 1'h1;
		rail_select         <= 1'h0;
		serial_data_out_int <= 1'h1;
		wr(4'h0, 8'h01);
		wr(4'h1, 8'h01);
		wr(4'h9, 8'hFF);
		rd(4'h0, 8'h01);
		rd(4'h2, 8'h70);
		wait_cyc(4);
		bit_chk(coder_enable, 1'h1);
		bit_chk(monitor_mode, 1'h1);
		bit_chk(monitor_or_serial_oe_n, 1'h0);
		bit_chk(monitor_or_serial_out, 1'h1);
		// Violation interrupt: raise, mask, unmask, clear
		wr(4'h3, 8'h03);
		wr(4'h4, 8'h01);
		rx_code_violation <= 1'h1;
		wait_cyc(24);
		bit_chk(irq, 1'h1);
		rd(4'h3, 8'h01);
		@(posedge ref_clk);
		rx_code_violation <= 1'h0;
		wait_cyc(24);
		bit_chk(neg_data_or_violation, 1'h0);
		wr(4'h4, 8'h00);
		wait_cyc(2);
		bit_chk(irq, 1'h0);
		wr(4'h4, 8'h01);
		wait_cyc(2);
		bit_chk(irq, 1'h1);
		wr(4'h3, 8'h01);
		wait_cyc(2);
		bit_chk(irq, 1'h0);
		// Single frequency: half period of two cycles
		wr(4'h5, 8'h02);
		single_freq_enable      <= 1'h1;
		single_freq_enable_oe_n <= 1'h0;
		wait_cyc(8);
		bit_chk(synth_enable, 1'h1);
		prev = synth_clock_out;
		n = 0;
		repeat (40)
		begin
			@(negedge ref_clk);
			if (synth_clock_out === 1'h1 && prev === 1'h0)
				n++;
			prev = synth_clock_out;
		end
		chk(n[7:0], 8'h0A);
		// Released pin still showing high must read as off
		@(posedge ref_clk);
		single_freq_enable_oe_n <= 1'h1;
		wait_cyc(8);
		bit_chk(synth_enable, 1'h0);
		bit_chk(synth_clock_out, 1'h0);
		// Inverted clock: data moves with the falling recovered clock
		wr(4'h1, 8'h03);
		rx_pos_pulse <= 1'h1;
		prev = recovered_clock;
		n = 0;
		repeat (40)
		begin
			@(negedge ref_clk);
			if (n == 0 && positive_data_out === 1'h1)
			begin
				n = 1;
				bit_chk(prev, 1'h1);
				bit_chk(recovered_clock, 1'h0);
			end
			prev = recovered_clock;
		end
		bit_chk(n[0], 1'h1);
		give_verdict();
	end
endmodule

bind rxocs_top rxocs_monitor checker_i
(
	.ref_clk, .rst_n, .select_a, .rail_select, .e3_select, .sts1_select,
	.single_freq_enable, .single_freq_enable_oe_n, .monitor_or_serial_in,
	.monitor_or_serial_oe_n, .monitor_mode, .coder_enable,
	.synth_enable, .synth_clock_out, .line_mode
);
